// ---- design/adc_acquire_convert_sequencer.sv ----
// a/d acquire and convert sequencer with apb register slave
// assumes apb master in the clock_in domain; analog sample switch and
// comparator outside; rc_tick_in is a synchronous pulse per rc period
//
// Functional notes
// - alignment bit seven picks right or left
// - acquisition code selects zero to twenty periods
// - clock code selects oscillator divide ratio
// - codes 011 and 111 select rc clock
// - rc clock starts one instruction cycle late
// - timing bit six always reads zero
// - reset clears registers, powers off, aborts
// - completion loads result, clears go, sets done
// - reset leaves result pair untouched
// - two periods wait before next acquisition
// - nonzero code samples then converts automatically
// - zero code converts at once on go
// - after conversion sampling resumes
// - go stays set through acquisition and conversion
// - conversion start opens the sampling switch
// - successive approximation, one bit per period
// - go reads one while busy, else zero
// - full conversion takes eleven periods
// - clearing go aborts, result pair kept
// - converter runs only while power enabled
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module adc_acquire_convert_sequencer
    import adc_seq_pkg::*;
#(
    parameter int TCY_CYCLES = TCY_OSC
)(
    input  wire logic                clock_in,
    input  wire logic                nrst_in,
    input  wire apb_req_s            apb_in,
    output logic [31:0]              prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    input  wire logic                rc_tick_in,
    input  wire logic                comparator_in,
    output logic                     sample_switch_out,
    output logic [RESULT_W-1:0]      trial_code_out,
    output logic                     converter_on_out,
    output logic                     busy_out,
    output logic                     conversion_done_flag_out
);

    typedef struct packed {
        seq_state_e        state;
        logic              converter_power_enable;
        logic              result_align_select;
        logic [2:0]        acq_time_select;
        logic [2:0]        conv_clock_select;
        logic              conversion_done_flag;
        logic [PER_W-1:0]  periods;
        logic [2:0]        delay_cnt;
        logic              sar_start;
        logic [7:0]        result_high_byte;
        logic [7:0]        result_low_byte;
    } seq_s;

    seq_s seq_ff;
    seq_s nxt_seq;

    logic                wr_access;
    logic                rd_access;
    logic                addr_hit;
    logic                tad_tick;
    logic                tad_run;
    logic                sar_abort;
    logic                sar_done;
    logic [RESULT_W-1:0] sar_result;
    logic [7:0]          timing_rd;
    logic                go_rd;
    logic                abort_go;

    assign wr_access = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign rd_access = apb_in.psel && apb_in.penable && !apb_in.pwrite;
    assign addr_hit  = (apb_in.paddr == CTRL0_OFS) || (apb_in.paddr == TIMING_OFS)
                    || (apb_in.paddr == RES_HIGH_OFS) || (apb_in.paddr == RES_LOW_OFS)
                    || (apb_in.paddr == STATUS_OFS);

    // zero wait states: every access completes in its first access cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = apb_in.psel && apb_in.penable && !addr_hit;

    assign go_rd     = seq_ff.converter_power_enable && (seq_ff.state != ST_IDLE)
                    && (seq_ff.state != ST_SETTLE);
    assign timing_rd = {seq_ff.result_align_select, 1'b0,
                        seq_ff.acq_time_select, seq_ff.conv_clock_select};

    always_comb
    begin
        prdata_out = 32'h0000_0000;
        if (rd_access)
        begin
            unique case (apb_in.paddr)
                CTRL0_OFS:    prdata_out = {30'h0, go_rd, seq_ff.converter_power_enable};
                TIMING_OFS:   prdata_out = {24'h0, timing_rd};
                RES_HIGH_OFS: prdata_out = {24'h0, seq_ff.result_high_byte};
                RES_LOW_OFS:  prdata_out = {24'h0, seq_ff.result_low_byte};
                STATUS_OFS:   prdata_out = {31'h0, seq_ff.conversion_done_flag};
                default:      prdata_out = 32'h0000_0000;
            endcase
        end
    end

    // period counts in acquire and settle only advance on conversion period ticks
    // an abort restarts the divider phase so the settle wait gets whole periods
    assign tad_run = ((seq_ff.state == ST_ACQUIRE) || (seq_ff.state == ST_CONVERT)
                  || (seq_ff.state == ST_SETTLE)) && !abort_go;

    tad_clock_gen #(
        .DW (DIV_W)
    ) u_tad (
        .clock_in     (clock_in),
        .nrst_in      (nrst_in),
        .run_in       (tad_run),
        .clk_sel_in   (seq_ff.conv_clock_select),
        .rc_tick_in   (rc_tick_in),
        .tad_tick_out (tad_tick)
    );

    sar_engine #(
        .RW (RESULT_W)
    ) u_sar (
        .clock_in       (clock_in),
        .nrst_in        (nrst_in),
        .start_in       (seq_ff.sar_start),
        .abort_in       (sar_abort),
        .tad_tick_in    (tad_tick),
        .comparator_in  (comparator_in),
        .trial_code_out (trial_code_out),
        .result_out     (sar_result),
        .done_out       (sar_done)
    );

    logic wr_ctrl0;
    logic wr_go;
    logic wr_power;

    assign wr_ctrl0 = wr_access && (apb_in.paddr == CTRL0_OFS);
    assign wr_go    = wr_ctrl0 && apb_in.pwdata[CTRL0_GO_BIT];
    assign wr_power = wr_ctrl0 ? apb_in.pwdata[CTRL0_POWER_BIT]
                               : seq_ff.converter_power_enable;
    assign abort_go = wr_ctrl0 && !apb_in.pwdata[CTRL0_GO_BIT]
                   && ((seq_ff.state == ST_ACQUIRE) || (seq_ff.state == ST_CONVERT)
                   || (seq_ff.state == ST_RC_DELAY));
    assign sar_abort = abort_go || !wr_power;

    always_comb
    begin
        nxt_seq           = seq_ff;
        nxt_seq.sar_start = 1'b0;
        nxt_seq.converter_power_enable = wr_power;

        if (wr_access && (apb_in.paddr == TIMING_OFS))
        begin
            nxt_seq.result_align_select = apb_in.pwdata[TIM_ALIGN_BIT];
            nxt_seq.acq_time_select     = apb_in.pwdata[TIM_ACQ_LSB +: 3];
            nxt_seq.conv_clock_select   = apb_in.pwdata[TIM_CLK_LSB +: 3];
        end
        if (wr_access && (apb_in.paddr == RES_HIGH_OFS))
            nxt_seq.result_high_byte = apb_in.pwdata[7:0];
        if (wr_access && (apb_in.paddr == RES_LOW_OFS))
            nxt_seq.result_low_byte = apb_in.pwdata[7:0];
        // write one to clear; a completion in the same cycle wins below
        if (wr_access && (apb_in.paddr == STATUS_OFS) && apb_in.pwdata[STATUS_DONE_BIT])
            nxt_seq.conversion_done_flag = 1'b0;

        unique case (seq_ff.state)
            ST_IDLE:
            begin
                nxt_seq.periods   = '0;
                nxt_seq.delay_cnt = 3'h0;
                if (wr_go && seq_ff.converter_power_enable)
                begin
                    if (clk_is_rc(seq_ff.conv_clock_select))
                        nxt_seq.state = ST_RC_DELAY;
                    else if (acq_periods(seq_ff.acq_time_select) != '0)
                        nxt_seq.state = ST_ACQUIRE;
                    else
                    begin
                        nxt_seq.state     = ST_CONVERT;
                        nxt_seq.sar_start = 1'b1;
                    end
                end
            end
            ST_RC_DELAY:
            begin
                nxt_seq.delay_cnt = seq_ff.delay_cnt + 3'h1;
                if (seq_ff.delay_cnt == 3'(TCY_CYCLES - 1))
                begin
                    if (acq_periods(seq_ff.acq_time_select) != '0)
                        nxt_seq.state = ST_ACQUIRE;
                    else
                    begin
                        nxt_seq.state     = ST_CONVERT;
                        nxt_seq.sar_start = 1'b1;
                    end
                end
            end
            ST_ACQUIRE:
            begin
                if (tad_tick)
                begin
                    nxt_seq.periods = seq_ff.periods + 5'h01;
                    if (seq_ff.periods + 5'h01 == acq_periods(seq_ff.acq_time_select))
                    begin
                        nxt_seq.state     = ST_CONVERT;
                        nxt_seq.sar_start = 1'b1;
                    end
                end
            end
            ST_CONVERT:
            begin
                nxt_seq.periods = '0;
                if (sar_done)
                begin
                    nxt_seq.state                = ST_SETTLE;
                    nxt_seq.conversion_done_flag = 1'b1;
                    if (seq_ff.result_align_select)
                    begin
                        nxt_seq.result_high_byte = {6'h00, sar_result[9:8]};
                        nxt_seq.result_low_byte  = sar_result[7:0];
                    end
                    else
                    begin
                        nxt_seq.result_high_byte = sar_result[9:2];
                        nxt_seq.result_low_byte  = {sar_result[1:0], 6'h00};
                    end
                end
            end
            ST_SETTLE:
            begin
                if (tad_tick)
                begin
                    nxt_seq.periods = seq_ff.periods + 5'h01;
                    if (seq_ff.periods + 5'h01 == 5'(SETTLE_PERIODS))
                        nxt_seq.state = ST_IDLE;
                end
            end
        endcase

        if (abort_go)
        begin
            nxt_seq.state   = ST_SETTLE;
            nxt_seq.periods = '0;
        end
        if (!wr_power)
            nxt_seq.state = ST_IDLE;
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            seq_ff                        <= seq_ff;
            seq_ff.state                  <= ST_IDLE;
            seq_ff.converter_power_enable <= 1'b0;
            seq_ff.result_align_select    <= 1'b0;
            seq_ff.acq_time_select        <= ACQ_RESET;
            seq_ff.conv_clock_select      <= CLK_RESET;
            seq_ff.conversion_done_flag   <= 1'b0;
            seq_ff.periods                <= '0;
            seq_ff.delay_cnt              <= 3'h0;
            seq_ff.sar_start              <= 1'b0;
            // result bytes deliberately keep their content through reset
            seq_ff.result_high_byte       <= seq_ff.result_high_byte;
            seq_ff.result_low_byte        <= seq_ff.result_low_byte;
        end
        else
        begin
            seq_ff <= nxt_seq;
        end
    end

    // sampling stops from conversion start through the settle wait
    assign sample_switch_out = seq_ff.converter_power_enable
                            && ((seq_ff.state == ST_IDLE) || (seq_ff.state == ST_ACQUIRE)
                            || (seq_ff.state == ST_RC_DELAY));
    assign converter_on_out         = seq_ff.converter_power_enable;
    assign busy_out                 = go_rd;
    assign conversion_done_flag_out = seq_ff.conversion_done_flag;

endmodule : adc_acquire_convert_sequencer

// ---- design/adc_seq_pkg.sv ----
// shared constants, register map, field layout and types of the a/d sequencer
// assumes a single system clock; the analog array and comparator live outside
package adc_seq_pkg;

    localparam logic [7:0] CTRL0_OFS       = 8'h00;
    localparam logic [7:0] TIMING_OFS      = 8'h04;
    localparam logic [7:0] RES_HIGH_OFS    = 8'h08;
    localparam logic [7:0] RES_LOW_OFS     = 8'h0c;
    localparam logic [7:0] STATUS_OFS      = 8'h10;

    localparam int         CTRL0_POWER_BIT = 0;
    localparam int         CTRL0_GO_BIT    = 1;
    localparam int         TIM_ALIGN_BIT   = 7;
    localparam int         TIM_ACQ_LSB     = 3;
    localparam int         TIM_CLK_LSB     = 0;
    localparam int         STATUS_DONE_BIT = 0;

    localparam logic [2:0] ACQ_RESET       = 3'h0;
    localparam logic [2:0] CLK_RESET       = 3'h0;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    localparam int         RESULT_W        = 10;
    localparam int         CONV_PERIODS    = 11;
    localparam int         SETTLE_PERIODS  = 2;
    localparam int         TCY_OSC         = 4;
    localparam int         DIV_W           = 7;
    localparam int         PER_W           = 5;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'b00001,
        ST_RC_DELAY = 5'b00010,
        ST_ACQUIRE  = 5'b00100,
        ST_CONVERT  = 5'b01000,
        ST_SETTLE   = 5'b10000
    } seq_state_e;

    function automatic logic [PER_W-1:0] acq_periods(input logic [2:0] sel);
        unique case (sel)
            3'h7: acq_periods = 5'h14;
            3'h6: acq_periods = 5'h10;
            3'h5: acq_periods = 5'h0c;
            3'h4: acq_periods = 5'h08;
            3'h3: acq_periods = 5'h06;
            3'h2: acq_periods = 5'h04;
            3'h1: acq_periods = 5'h02;
            3'h0: acq_periods = 5'h00;
        endcase
    endfunction : acq_periods

    function automatic logic [DIV_W-1:0] clk_divisor(input logic [2:0] sel);
        unique case (sel)
            3'h0:    clk_divisor = 7'h02;
            3'h1:    clk_divisor = 7'h08;
            3'h2:    clk_divisor = 7'h20;
            3'h4:    clk_divisor = 7'h04;
            3'h5:    clk_divisor = 7'h10;
            3'h6:    clk_divisor = 7'h40;
            default: clk_divisor = 7'h02;
        endcase
    endfunction : clk_divisor

    function automatic logic clk_is_rc(input logic [2:0] sel);
        clk_is_rc = (sel[1:0] == 2'h3);
    endfunction : clk_is_rc

endpackage : adc_seq_pkg

// ---- design/tad_clock_gen.sv ----
// conversion period tick generator: oscillator divider or rc source
// assumes rc_tick_in is a one-cycle pulse synchronous to clock_in
`timescale 1ns/1ps
module tad_clock_gen
    import adc_seq_pkg::*;
#(
    parameter int DW = DIV_W
)(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       run_in,
    input  wire logic [2:0] clk_sel_in,
    input  wire logic       rc_tick_in,
    output logic            tad_tick_out
);

    typedef struct packed {
        logic [DW-1:0] cnt;
        logic          tick;
    } gen_s;

    gen_s gen_ff;
    gen_s nxt_gen;

    always_comb
    begin
        nxt_gen      = gen_ff;
        nxt_gen.tick = 1'b0;
        if (!run_in)
        begin
            // restart phase so each sequence sees whole periods
            nxt_gen.cnt = '0;
        end
        else if (clk_is_rc(clk_sel_in))
        begin
            nxt_gen.tick = rc_tick_in;
        end
        else if (gen_ff.cnt + 1'b1 == DW'(clk_divisor(clk_sel_in)))
        begin
            nxt_gen.cnt  = '0;
            nxt_gen.tick = 1'b1;
        end
        else
        begin
            nxt_gen.cnt = gen_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
            gen_ff <= '0;
        else
            gen_ff <= nxt_gen;
    end

    assign tad_tick_out = gen_ff.tick;

endmodule : tad_clock_gen

// ---- design/sar_engine.sv ----
// successive approximation register: one setup period then one decision per period
// assumes comparator_in is high when the held sample is at or above trial_code_out
`timescale 1ns/1ps
module sar_engine
    import adc_seq_pkg::*;
#(
    parameter int RW = RESULT_W
)(
    input  wire logic          clock_in,
    input  wire logic          nrst_in,
    input  wire logic          start_in,
    input  wire logic          abort_in,
    input  wire logic          tad_tick_in,
    input  wire logic          comparator_in,
    output logic [RW-1:0]      trial_code_out,
    output logic [RW-1:0]      result_out,
    output logic               done_out
);

    typedef struct packed {
        logic          busy;
        logic [3:0]    step;
        logic [RW-1:0] code;
        logic [RW-1:0] result;
        logic          done;
    } sar_s;

    sar_s sar_ff;
    sar_s nxt_sar;
    logic [3:0] idx;

    always_comb
    begin
        nxt_sar      = sar_ff;
        nxt_sar.done = 1'b0;
        idx          = 4'(RW) - sar_ff.step;
        if (abort_in)
        begin
            nxt_sar.busy = 1'b0;
            nxt_sar.code = '0;
        end
        else if (start_in)
        begin
            nxt_sar.busy = 1'b1;
            nxt_sar.step = 4'h0;
            nxt_sar.code = '0;
        end
        else if (sar_ff.busy && tad_tick_in)
        begin
            nxt_sar.step = sar_ff.step + 4'h1;
            if (sar_ff.step == 4'h0)
            begin
                nxt_sar.code[RW-1] = 1'b1;
            end
            else
            begin
                nxt_sar.code[idx] = comparator_in;
                if (idx != 4'h0)
                    nxt_sar.code[idx - 4'h1] = 1'b1;
                if (sar_ff.step == 4'(CONV_PERIODS - 1))
                begin
                    nxt_sar.result = nxt_sar.code;
                    nxt_sar.done   = 1'b1;
                    nxt_sar.busy   = 1'b0;
                    // trial code back to zero so the array idles outside conversion
                    nxt_sar.code   = '0;
                end
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
            sar_ff <= '0;
        else
            sar_ff <= nxt_sar;
    end

    assign trial_code_out = sar_ff.code;
    assign result_out     = sar_ff.result;
    assign done_out       = sar_ff.done;

endmodule : sar_engine

// ---- tb/adc_seq_assertions.sv ----
// concurrent checks on the sequencer top ports
// assumes it is bound to the sequencer top from the bench
`timescale 1ns/1ps
module adc_seq_assertions
    import adc_seq_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                nrst_in,
    input  wire apb_req_s            apb_in,
    input  wire logic [31:0]         prdata_out,
    input  wire logic                sample_switch_out,
    input  wire logic [RESULT_W-1:0] trial_code_out,
    input  wire logic                converter_on_out,
    input  wire logic                busy_out,
    input  wire logic                conversion_done_flag_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    // clocks spent converting; saturates so a stuck state cannot wrap
    logic [7:0] conv_cnt_ff;
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in || sample_switch_out || !busy_out)
            conv_cnt_ff <= 8'h00;
        else if (conv_cnt_ff != 8'hff)
            conv_cnt_ff <= conv_cnt_ff + 8'h01;
    end

    reset_state_a: assert property (
        $rose(nrst_in) |-> !busy_out && !converter_on_out && !conversion_done_flag_out)
        else $error("state not cleared by reset");
    done_ends_busy_a: assert property (
        $rose(conversion_done_flag_out) |-> !busy_out && $past(busy_out))
        else $error("done without go clearing");
    busy_power_a: assert property (busy_out |-> converter_on_out)
        else $error("busy while powered off");
    busy_from_go_a: assert property (
        $rose(busy_out) |-> $past(apb_in.psel && apb_in.penable && apb_in.pwrite
            && apb_in.paddr == CTRL0_OFS && apb_in.pwdata[1]))
        else $error("busy rose without go write");
    switch_open_a: assert property ((trial_code_out != '0) |-> !sample_switch_out)
        else $error("trial code while sampling");
    settle_resume_a: assert property (
        $fell(busy_out) && converter_on_out |-> !sample_switch_out [*2] ##[1:300] sample_switch_out)
        else $error("settle wait or resume wrong");
    conv_length_a: assert property (
        $rose(conversion_done_flag_out) |-> conv_cnt_ff >= 8'h14)
        else $error("conversion too short");
    bit6_zero_a: assert property (
        apb_in.psel && apb_in.penable && !apb_in.pwrite && apb_in.paddr == TIMING_OFS
        |-> prdata_out[6] == 1'b0 && prdata_out[31:8] == 24'h0)
        else $error("reserved timing bits not zero");
endmodule : adc_seq_assertions

// ---- tb/analog_front_model.sv ----
// holding capacitor, comparator and free running rc oscillator
// assumes level_in is the analog input expressed as a code
`timescale 1ns/1ps
module analog_front_model
    import adc_seq_pkg::*;
#(
    parameter int RC_PER = 6
)(
    input  wire logic                clock_in,
    input  wire logic                sample_switch_in,
    input  wire logic [RESULT_W-1:0] trial_code_in,
    input  wire logic [RESULT_W-1:0] level_in,
    output logic                     comparator_out,
    output logic                     rc_tick_out
);
    logic [RESULT_W-1:0] held_ff = '0;
    int                  rc_cnt  = 0;
    // capacitor follows the input only while the switch is closed
    always_ff @(posedge clock_in)
        if (sample_switch_in)
            held_ff <= level_in;
    assign comparator_out = (held_ff >= trial_code_in);
    // oscillator runs free, unrelated to conversions
    always_ff @(posedge clock_in)
        rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
    assign rc_tick_out = (rc_cnt == RC_PER - 1);
endmodule : analog_front_model

// ---- tb/testbench.sv ----
// bench: random and corner conversions driven over apb
// assumes the analog front model and checker of this folder
`timescale 1ns/1ps
module testbench
    import adc_seq_pkg::*;
;
    localparam int TCY   = 3;
    localparam int RCP   = 6;
    localparam int LIMIT = 30000;
    logic                clock_in = 1'b0;
    logic                nrst_in  = 1'b0;
    apb_req_s            apb      = '0;
    logic [RESULT_W-1:0] level    = '0;
    logic [31:0]         prdata, rdv;
    logic                pready, pslverr, rc_tick, cmp, sw, pwr, busy, done, err;
    logic [RESULT_W-1:0] trial;
    logic [15:0]         exp_pair;
    int                  fails    = 0;
    int                  n_checks = 0;
    int                  cycles   = 0;
    int                  acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int                  div_tab [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

    adc_acquire_convert_sequencer #(.TCY_CYCLES(TCY)) i_adc_acquire_convert_sequencer (
        .clock_in(clock_in), .nrst_in(nrst_in), .apb_in(apb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rc_tick_in(rc_tick),
        .comparator_in(cmp), .sample_switch_out(sw), .trial_code_out(trial),
        .converter_on_out(pwr), .busy_out(busy), .conversion_done_flag_out(done));
    analog_front_model #(.RC_PER(RCP)) i_analog_front_model (
        .clock_in(clock_in), .sample_switch_in(sw), .trial_code_in(trial),
        .level_in(level), .comparator_out(cmp), .rc_tick_out(rc_tick));

    initial forever #10 clock_in = ~clock_in;

    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // idle cycle first so back to back calls never drive psel twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        apb.psel    <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite  <= w;
        apb.paddr   <= a;
        apb.pwdata  <= d;
        @(posedge clock_in);
        apb.penable <= 1'b1;
        do
            @(posedge clock_in);
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, exp, rdv);
    endtask : rdc

    function automatic logic [15:0] pair(input logic [9:0] v, input logic right);
        pair = right ? {6'h00, v} : {v, 6'h00};
    endfunction : pair

    task automatic convert(input logic [2:0] a, input logic [2:0] c, input logic al);
        int   n;
        int   p;
        logic ok;
        level <= 10'($urandom);
        wr(TIMING_OFS, {24'h0, al, 1'b0, a, c});
        wr(CTRL0_OFS, 32'h3);
        exp_pair = pair(level, al);
        p  = acq_tab[a] + CONV_PERIODS;
        n  = 0;
        ok = 1'b1;
        do
        begin
            @(posedge clock_in);
            #1;
            n++;
            if (done !== 1'b1)
                ok &= (busy === 1'b1);
        end
        while (done !== 1'b1 && n < 3000);
        check("busy held", 32'h1, 32'(ok));
        check("busy after done", 32'h0, 32'(busy));
        if (c[1:0] == 2'h3) // rc source, as software picks for sleep
            check("rc time", 32'h1, 32'(n > TCY + (p - 1) * RCP && n <= TCY + p * RCP + 3));
        else
            check("time", 32'(p * div_tab[c] + 2), 32'(n));
        rdc("result high", RES_HIGH_OFS, {24'h0, exp_pair[15:8]});
        rdc("result low", RES_LOW_OFS, {24'h0, exp_pair[7:0]});
        rdc("done set", STATUS_OFS, 32'h1);
        wr(STATUS_OFS, 32'h1);
        rdc("done clear", STATUS_OFS, 32'h0);
        n = 0;
        while (sw !== 1'b1 && n < 400)
        begin
            @(posedge clock_in);
            n++;
        end
        check("sampling again", 32'h1, 32'(sw));
    endtask : convert

    initial
    begin
        void'($urandom(32'h1f9ea799));
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'b1;
        rdc("timing reset", TIMING_OFS, 32'h0);
        rdc("ctrl reset", CTRL0_OFS, 32'h0);
        wr(TIMING_OFS, 32'hff);
        rdc("timing bit6", TIMING_OFS, 32'hbf);
        xfer(1'b0, 8'h14, 32'h0);
        check("unmapped error", 32'h1, 32'(err));
        wr(CTRL0_OFS, 32'h2);
        #1;
        check("go unpowered", 32'h0, 32'(busy));
        wr(CTRL0_OFS, 32'h1);
        #1;
        check("power on", 32'h1, 32'(pwr));
        // every acquisition and clock code once, then random picks
        for (int i = 0; i < 8; i++)
            convert(3'(i), 3'(7 - i), 1'($urandom));
        repeat (4)
            convert(3'($urandom), 3'($urandom), 1'($urandom));
        // abort in mid conversion keeps the old pair
        wr(TIMING_OFS, 32'h86);
        wr(CTRL0_OFS, 32'h3);
        repeat (200) @(posedge clock_in);
        wr(CTRL0_OFS, 32'h1);
        #1;
        check("busy abort", 32'h0, 32'(busy));
        repeat (800) @(posedge clock_in);
        check("no done on abort", 32'h0, 32'(done));
        rdc("kept low", RES_LOW_OFS, {24'h0, exp_pair[7:0]});
        // power off in mid conversion drops it at once
        wr(CTRL0_OFS, 32'h3);
        repeat (20) @(posedge clock_in);
        wr(CTRL0_OFS, 32'h0);
        #1;
        check("power off abort", 32'h0, 32'(busy));
        wr(CTRL0_OFS, 32'h1);
        // reset in mid run leaves the result pair alone
        wr(CTRL0_OFS, 32'h3);
        repeat (20) @(posedge clock_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        rdc("ctrl after reset", CTRL0_OFS, 32'h0);
        rdc("kept high", RES_HIGH_OFS, {24'h0, exp_pair[15:8]});
        complete_run();
    end
endmodule : testbench

bind adc_acquire_convert_sequencer adc_seq_assertions i_adc_seq_assertions (
    .clock_in(clock_in), .nrst_in(nrst_in), .apb_in(apb_in), .prdata_out(prdata_out),
    .sample_switch_out(sample_switch_out), .trial_code_out(trial_code_out),
    .converter_on_out(converter_on_out), .busy_out(busy_out),
    .conversion_done_flag_out(conversion_done_flag_out));
